/* File: inc/cst_params.svh */
`ifndef CST_PARAMS_SVH
`define CST_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CST_OFF_CAL         8'h55
`define CST_OFF_MODEM       8'h56
`define CST_OFF_CP_TEST     8'h57
`define CST_OFF_CP_TRIM     8'h58
`define CST_OFF_DIV_TRIM    8'h59

// ****************************************************************
// Calibration control field positions
// ****************************************************************
`define CST_BIT_XTAL_HALF   6
`define CST_BIT_RC_FINE_EN  4
`define CST_BIT_RC_FORCE    3
`define CST_BIT_VCO_DP      2
`define CST_BIT_VCO_FORCE   1
`define CST_BIT_SKIP_VCO    0

// ****************************************************************
// Charge pump trim field positions
// ****************************************************************
`define CST_CP_GAIN_MSB     7
`define CST_CP_GAIN_LSB     6
`define CST_BIT_CP_OVR      5
`define CST_CP_CORR_MSB     4
`define CST_CP_CORR_LSB     0

// ****************************************************************
// Reset values, VCO boost value and OOK preamble bit counts
// ****************************************************************
`define CST_RST_CAL         8'h44
`define CST_RST_MODEM       8'h00
`define CST_RST_CP_TEST     8'h00
`define CST_RST_CP_GAIN     2'h2
`define CST_RST_CP_CORR     5'h00
`define CST_RST_DIV_TRIM    8'h00
`define CST_VCO_BOOST_VAL   4'hF
`define CST_OOK_BITS_SHORT  4'h4
`define CST_OOK_BITS_LONG   4'h8

// ****************************************************************
// Timing
// ****************************************************************
`define CST_CLK_MHZ         100
`define CST_RC_CAL_US       2000
`define CST_RC_FINE_S       30
`define CST_XTAL_WAKE_US    1000
`define CST_VCO_CAL_US      50
`define CST_RC_CAL_CYC      (`CST_RC_CAL_US * `CST_CLK_MHZ)
`define CST_RC_FINE_CYC     (64'(`CST_RC_FINE_S) * 64'(`CST_CLK_MHZ) * 64'd1000000)
`define CST_XTAL_WAKE_CYC   (`CST_XTAL_WAKE_US * `CST_CLK_MHZ)
`define CST_VCO_CAL_CYC     (`CST_VCO_CAL_US * `CST_CLK_MHZ)

`endif

/* File: inc/cst_pkg.sv */
package cst_pkg;

    typedef enum logic [0:0] {
        CST_VC_IDLE,
        CST_VC_CAL
    } cst_vstate_t;

    typedef struct packed {
        logic bcr_bypass;
        logic slicer_bypass;
        logic dither_pm1;
        logic osc_det_off;
        logic ook_th8;
        logic refclk_10m;
        logic refclk_inv;
        logic disc_toggle;
    } cst_modem_t;

    typedef struct packed {
        logic       pfd_rst;
        logic       fbdiv_rst;
        logic       force_up;
        logic       force_dn;
        logic       dc_only;
        logic [2:0] dc_curr;
    } cst_cp_test_t;

    typedef struct packed {
        logic       tx_boost;
        logic       fbdiv_hc;
        logic [1:0] d3_trim;
        logic [1:0] d2_trim;
        logic [1:0] d1p5_trim;
    } cst_div_trim_t;

    typedef struct packed {
        logic          xtal_half;
        logic          rc_fine_en;
        logic          rc_force;
        logic          vco_dp;
        logic          vco_force;
        logic          skip_vco;
        cst_modem_t    modem;
        cst_cp_test_t  cp_test;
        logic [1:0]    cp_gain;
        logic          cp_ovr;
        logic [4:0]    cp_wr;
        logic [4:0]    cp_corr;
        cst_div_trim_t div_trim;
        logic [7:0]    rdata;
        logic          rc_busy;
        logic [31:0]   rc_cnt;
        logic [31:0]   fine_cnt;
        logic          wut_q;
        cst_vstate_t   vstate;
        logic [31:0]   v_cnt;
        logic [31:0]   v_len;
        logic          v_to_tx;
        logic          tx_go;
        logic          x_busy;
        logic [31:0]   x_cnt;
        logic [31:0]   x_len;
        logic          x_ready;
        logic [3:0]    vco_corr;
        logic [3:0]    ook_bits;
        logic          osc_det_en;
    } cst_state_t;

endpackage : cst_pkg

/* File: hw/cst_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cst_params.svh"

module cst_regs #(
    parameter logic [31:0] P_RC_CAL_CYCLES    = 32'(`CST_RC_CAL_CYC),
    parameter logic [31:0] P_RC_FINE_CYCLES   = 32'(`CST_RC_FINE_CYC),
    parameter logic [31:0] P_XTAL_WAKE_CYCLES = 32'(`CST_XTAL_WAKE_CYC),
    parameter logic [31:0] P_VCO_CAL_CYCLES   = 32'(`CST_VCO_CAL_CYC)
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    // Register port
    input  wire logic [7:0]             i_addr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output var  logic [7:0]             o_rdata,
    // Device status
    input  wire logic                   i_idle,
    input  wire logic                   i_pllon,
    input  wire logic                   i_tx_mode,
    input  wire logic                   i_tx_req,
    input  wire logic                   i_wut_en,
    input  wire logic                   i_rc_osc_en,
    input  wire logic                   i_xtal_wake_start,
    input  wire logic [4:0]             i_cp_corr_auto,
    input  wire logic [3:0]             i_vco_corr,
    // Calibration sequencing
    output var  logic                   o_rc_cal_busy,
    output var  logic                   o_vco_cal_busy,
    output var  logic                   o_vco_cal_long,
    output var  logic                   o_tx_go,
    output var  logic                   o_xtal_ready,
    output var  logic [3:0]             o_vco_corr,
    // Modem controls
    output var  cst_pkg::cst_modem_t    o_modem,
    output var  logic [3:0]             o_ook_pre_bits,
    output var  logic                   o_osc_det_en,
    // Synthesizer trims
    output var  cst_pkg::cst_cp_test_t  o_cp_test,
    output var  logic [1:0]             o_cp_gain,
    output var  logic [4:0]             o_cp_corr,
    output var  cst_pkg::cst_div_trim_t o_div_trim
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic cst_hit(input logic [7:0] addr, input logic [7:0] off);
        cst_hit = (addr == off);
    endfunction : cst_hit

    cst_pkg::cst_state_t st;
    cst_pkg::cst_state_t next_st;

    logic wr_cal;
    logic wr_modem;
    logic wr_cp_test;
    logic wr_cp_trim;
    logic wr_div;
    logic rc_force_rise;
    logic fine_due;
    logic wut_rise;
    logic rc_req;
    logic vco_force_ok;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st    = st;
        wr_cal     = i_wr && cst_hit(i_addr, `CST_OFF_CAL);
        wr_modem   = i_wr && cst_hit(i_addr, `CST_OFF_MODEM);
        wr_cp_test = i_wr && cst_hit(i_addr, `CST_OFF_CP_TEST);
        wr_cp_trim = i_wr && cst_hit(i_addr, `CST_OFF_CP_TRIM);
        wr_div     = i_wr && cst_hit(i_addr, `CST_OFF_DIV_TRIM);

        next_st.tx_go   = 1'b0;
        next_st.x_ready = 1'b0;
        next_st.rdata   = 8'h00;

        // Crystal wake timer; length fixed at start so a mid-wake write is harmless
        if (st.x_busy) begin
            if (st.x_cnt >= st.x_len - 32'h1) begin
                next_st.x_busy  = 1'b0;
                next_st.x_ready = 1'b1;
            end else begin
                next_st.x_cnt = st.x_cnt + 32'h1;
            end
        end else if (i_xtal_wake_start) begin
            next_st.x_busy = 1'b1;
            next_st.x_cnt  = 32'h0;
            next_st.x_len  = st.xtal_half ? (P_XTAL_WAKE_CYCLES >> 1)
                                          : P_XTAL_WAKE_CYCLES;
        end

        // RC oscillator calibration
        rc_force_rise = wr_cal && i_wdata[`CST_BIT_RC_FORCE] && !st.rc_force;
        wut_rise      = i_wut_en && !st.wut_q;
        fine_due      = st.rc_fine_en && (st.fine_cnt >= P_RC_FINE_CYCLES - 32'h1);
        rc_req        = rc_force_rise || wut_rise || fine_due;
        next_st.wut_q = i_wut_en;
        if (st.rc_fine_en && !fine_due) begin
            next_st.fine_cnt = st.fine_cnt + 32'h1;
        end else begin
            next_st.fine_cnt = 32'h0;
        end
        if (st.rc_busy) begin
            if (st.rc_cnt >= P_RC_CAL_CYCLES - 32'h1) begin
                next_st.rc_busy  = 1'b0;
                next_st.rc_force = 1'b0;
            end else begin
                next_st.rc_cnt = st.rc_cnt + 32'h1;
            end
        end else begin
            // Without the 32 kHz oscillator there is nothing to calibrate
            if (rc_req && i_rc_osc_en) begin
                next_st.rc_busy = 1'b1;
                next_st.rc_cnt  = 32'h0;
            end
            if (!i_rc_osc_en) begin
                next_st.rc_force = 1'b0;
            end
        end

        // VCO calibration sequencer
        vco_force_ok = st.vco_force && i_idle && i_pllon;
        case (st.vstate)
            cst_pkg::CST_VC_IDLE: begin
                if (i_tx_req && st.skip_vco) begin
                    next_st.tx_go = 1'b1;
                end else if (i_tx_req || vco_force_ok) begin
                    next_st.vstate  = cst_pkg::CST_VC_CAL;
                    next_st.v_cnt   = 32'h0;
                    next_st.v_to_tx = i_tx_req;
                    next_st.v_len   = st.vco_dp ? (P_VCO_CAL_CYCLES << 1)
                                                : P_VCO_CAL_CYCLES;
                end
                // Force outside Idle/PLL-on has no effect and is dropped
                next_st.vco_force = 1'b0;
            end
            cst_pkg::CST_VC_CAL: begin
                if (i_tx_req) begin
                    next_st.v_to_tx = 1'b1;
                end
                if (st.v_cnt >= st.v_len - 32'h1) begin
                    next_st.vstate    = cst_pkg::CST_VC_IDLE;
                    next_st.vco_force = 1'b0;
                    next_st.tx_go     = st.v_to_tx || i_tx_req;
                    next_st.v_to_tx   = 1'b0;
                end else begin
                    next_st.v_cnt = st.v_cnt + 32'h1;
                end
            end
            default: begin
                next_st.vstate = cst_pkg::CST_VC_IDLE;
            end
        endcase

        // Register writes after hardware clears: a set in the same cycle wins
        if (wr_cal) begin
            next_st.xtal_half  = i_wdata[`CST_BIT_XTAL_HALF];
            next_st.rc_fine_en = i_wdata[`CST_BIT_RC_FINE_EN];
            next_st.rc_force   = i_wdata[`CST_BIT_RC_FORCE];
            next_st.vco_dp     = i_wdata[`CST_BIT_VCO_DP];
            next_st.vco_force  = i_wdata[`CST_BIT_VCO_FORCE];
            next_st.skip_vco   = i_wdata[`CST_BIT_SKIP_VCO];
        end
        if (wr_modem) begin
            next_st.modem = cst_pkg::cst_modem_t'(i_wdata);
        end
        if (wr_cp_test) begin
            next_st.cp_test = cst_pkg::cst_cp_test_t'(i_wdata);
        end
        if (wr_cp_trim) begin
            next_st.cp_gain = i_wdata[`CST_CP_GAIN_MSB:`CST_CP_GAIN_LSB];
            next_st.cp_ovr  = i_wdata[`CST_BIT_CP_OVR];
            next_st.cp_wr   = i_wdata[`CST_CP_CORR_MSB:`CST_CP_CORR_LSB];
        end
        if (wr_div) begin
            next_st.div_trim = cst_pkg::cst_div_trim_t'(i_wdata);
        end

        // Pump correction follows the loop unless overridden
        next_st.cp_corr = next_st.cp_ovr ? next_st.cp_wr : i_cp_corr_auto;

        // Decoded modem controls
        next_st.ook_bits   = next_st.modem.ook_th8 ? `CST_OOK_BITS_LONG
                                                   : `CST_OOK_BITS_SHORT;
        next_st.osc_det_en = !next_st.modem.osc_det_off;

        // VCO current correction boost
        if (st.div_trim.tx_boost
            && (i_tx_mode || (st.vstate == cst_pkg::CST_VC_CAL && st.v_to_tx))) begin
            next_st.vco_corr = `CST_VCO_BOOST_VAL;
        end else begin
            next_st.vco_corr = i_vco_corr;
        end

        // Read path; reserved bits always read as constant zero, whatever was written
        if (i_rd) begin
            if (cst_hit(i_addr, `CST_OFF_CAL)) begin
                next_st.rdata = {1'b0, st.xtal_half, 1'b0, st.rc_fine_en,
                                 st.rc_force, st.vco_dp, st.vco_force,
                                 st.skip_vco};
            end else if (cst_hit(i_addr, `CST_OFF_MODEM)) begin
                next_st.rdata = st.modem;
            end else if (cst_hit(i_addr, `CST_OFF_CP_TEST)) begin
                next_st.rdata = st.cp_test;
            end else if (cst_hit(i_addr, `CST_OFF_CP_TRIM)) begin
                // Override shows the written value, which the pump takes in the same cycle
                next_st.rdata = {st.cp_gain, st.cp_ovr,
                                 st.cp_ovr ? st.cp_wr : st.cp_corr};
            end else if (cst_hit(i_addr, `CST_OFF_DIV_TRIM)) begin
                next_st.rdata = st.div_trim;
            end else begin
                next_st.rdata = 8'h00;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st            <= '0;
            st.xtal_half  <= 1'(`CST_RST_CAL >> `CST_BIT_XTAL_HALF);
            st.vco_dp     <= 1'(`CST_RST_CAL >> `CST_BIT_VCO_DP);
            st.modem      <= `CST_RST_MODEM;
            st.cp_test    <= `CST_RST_CP_TEST;
            st.cp_gain    <= `CST_RST_CP_GAIN;
            st.cp_wr      <= `CST_RST_CP_CORR;
            st.cp_corr    <= `CST_RST_CP_CORR;
            st.div_trim   <= `CST_RST_DIV_TRIM;
            st.vstate     <= cst_pkg::CST_VC_IDLE;
            st.ook_bits   <= `CST_OOK_BITS_SHORT;
            st.osc_det_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_rdata        = st.rdata;
    assign o_rc_cal_busy  = st.rc_busy;
    assign o_vco_cal_busy = (st.vstate == cst_pkg::CST_VC_CAL);
    assign o_vco_cal_long = st.vco_dp;
    assign o_tx_go        = st.tx_go;
    assign o_xtal_ready   = st.x_ready;
    assign o_vco_corr     = st.vco_corr;
    assign o_modem        = st.modem;
    assign o_ook_pre_bits = st.ook_bits;
    assign o_osc_det_en   = st.osc_det_en;
    assign o_cp_test      = st.cp_test;
    assign o_cp_gain      = st.cp_gain;
    assign o_cp_corr      = st.cp_corr;
    assign o_div_trim     = st.div_trim;

endmodule : cst_regs

`default_nettype wire

/* File: verification/cst_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Host side of the register port
// ****************************************************************
module cst_host (
    // Clock and read data
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    // Register port
    output var  logic [7:0] o_addr,
    output var  logic [7:0] o_wdata,
    output var  logic       o_wr,
    output var  logic       o_rd
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    // Idle lines flip so stale values never look valid
    task automatic release_bus;
        o_addr  <= ~o_addr;
        o_wdata <= ~o_wdata;
    endtask : release_bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        release_bus();
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        release_bus();
        #1;
        d = i_rdata;
    endtask : rd
endmodule : cst_host
`default_nettype wire

/* File: verification/cst_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module cst_regs_chk #(
    parameter logic [31:0] P_RC_CAL_CYCLES  = 32'd20,
    parameter logic [31:0] P_VCO_CAL_CYCLES = 32'd8
) (
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_resetn,
    // Watched ports
    input  wire logic [7:0]          i_addr,
    input  wire logic [7:0]          i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    input  wire logic                i_rc_osc_en,
    input  wire logic                i_tx_mode,
    input  wire logic [3:0]          i_vco_corr,
    input  wire logic [7:0]          o_rdata,
    input  wire logic                o_rc_cal_busy,
    input  wire logic                o_vco_cal_busy,
    input  wire logic                o_vco_cal_long,
    input  wire logic [3:0]          o_vco_corr,
    input  wire cst_pkg::cst_modem_t o_modem,
    input  wire logic [3:0]          o_ook_pre_bits,
    input  wire logic                o_osc_det_en,
    input  wire logic [4:0]          o_cp_corr,
    input  wire cst_pkg::cst_div_trim_t o_div_trim
);
    localparam int RC_M1 = P_RC_CAL_CYCLES - 1;
    localparam int VC_M1 = P_VCO_CAL_CYCLES - 1;
    localparam int VD_M1 = 2 * P_VCO_CAL_CYCLES - 1;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_rc_run; ##RC_M1 o_rc_cal_busy ##1 !o_rc_cal_busy; endsequence
    sequence s_vc_run; ##VC_M1 o_vco_cal_busy ##1 !o_vco_cal_busy; endsequence
    sequence s_vd_run; ##VD_M1 o_vco_cal_busy ##1 !o_vco_cal_busy; endsequence

    property p_rc_len; $rose(o_rc_cal_busy) |-> s_rc_run; endproperty
    property p_rc_osc; $rose(o_rc_cal_busy) |-> $past(i_rc_osc_en); endproperty
    property p_vc_len; $rose(o_vco_cal_busy) && !o_vco_cal_long |-> s_vc_run; endproperty
    property p_vd_len; $rose(o_vco_cal_busy) && o_vco_cal_long |-> s_vd_run; endproperty
    property p_modem_wr; i_wr && i_addr == 8'h56 |=> o_modem == $past(i_wdata); endproperty
    property p_osc_det; o_osc_det_en == !o_modem.osc_det_off; endproperty
    property p_ook; o_ook_pre_bits == (o_modem.ook_th8 ? 4'h8 : 4'h4); endproperty
    property p_cp_rst; $rose(i_resetn) |-> o_cp_corr == 5'h00; endproperty
    property p_boost; o_div_trim.tx_boost && i_tx_mode |=> o_vco_corr == 4'hF; endproperty
    property p_pass; !o_div_trim.tx_boost |=> o_vco_corr == $past(i_vco_corr); endproperty
    property p_rsv; i_rd && i_addr == 8'h55 |=> o_rdata[7] == 1'b0 && o_rdata[5] == 1'b0;
    endproperty

    a_rc_len: assert property (p_rc_len) else $error("rc cal length wrong");
    a_rc_osc: assert property (p_rc_osc) else $error("rc cal without osc");
    a_vc_len: assert property (p_vc_len) else $error("vco cal length wrong");
    a_vd_len: assert property (p_vd_len) else $error("long vco cal length wrong");
    a_modem_wr: assert property (p_modem_wr) else $error("modem reg not applied");
    a_osc_det: assert property (p_osc_det) else $error("osc detect enable wrong");
    a_ook: assert property (p_ook) else $error("ook preamble count wrong");
    a_cp_rst: assert property (p_cp_rst) else $error("cp corr not zero at reset");
    a_boost: assert property (p_boost) else $error("vco corr not boosted");
    a_pass: assert property (p_pass) else $error("vco corr not passed");
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
endmodule : cst_regs_chk

bind cst_regs cst_regs_chk #(
    .P_RC_CAL_CYCLES (P_RC_CAL_CYCLES),
    .P_VCO_CAL_CYCLES(P_VCO_CAL_CYCLES)
) u_chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_rc_osc_en(i_rc_osc_en), .i_tx_mode(i_tx_mode),
    .i_vco_corr(i_vco_corr), .o_rdata(o_rdata), .o_rc_cal_busy(o_rc_cal_busy),
    .o_vco_cal_busy(o_vco_cal_busy), .o_vco_cal_long(o_vco_cal_long),
    .o_vco_corr(o_vco_corr), .o_modem(o_modem), .o_ook_pre_bits(o_ook_pre_bits),
    .o_osc_det_en(o_osc_det_en), .o_cp_corr(o_cp_corr), .o_div_trim(o_div_trim)
);
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module testbench;
    // Short counts keep the run brief
    localparam logic [31:0] RC = 32'd20, FINE = 32'd50, XW = 32'd16, VC = 32'd8;
    logic clk = 1'b0, rstn = 1'b0;
    logic idle = 1'b0, pllon = 1'b0, txm = 1'b0, txr = 1'b0;
    logic wut = 1'b0, rco = 1'b0, xws = 1'b0;
    logic [4:0] cpa = 5'h00;
    logic [3:0] vci = 4'h0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, rcb, vcb, vcl, txg, xr, odet;
    logic [3:0] vco, ook;
    logic [1:0] cpg;
    logic [4:0] cpc;
    cst_pkg::cst_modem_t modem;
    cst_pkg::cst_cp_test_t cpt;
    cst_pkg::cst_div_trim_t dvt;
    int err_count = 0, n_compared = 0, t, n;
    wire logic [3:0] mon = {xr, txg, vcb, rcb};

    always #5 clk = ~clk;

    cst_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
                   .o_wr(wr), .o_rd(rd));
    cst_regs #(.P_RC_CAL_CYCLES(RC), .P_RC_FINE_CYCLES(FINE), .P_XTAL_WAKE_CYCLES(XW),
               .P_VCO_CAL_CYCLES(VC)) dut (
        .i_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_idle(idle), .i_pllon(pllon), .i_tx_mode(txm),
        .i_tx_req(txr), .i_wut_en(wut), .i_rc_osc_en(rco), .i_xtal_wake_start(xws),
        .i_cp_corr_auto(cpa), .i_vco_corr(vci), .o_rc_cal_busy(rcb), .o_vco_cal_busy(vcb),
        .o_vco_cal_long(vcl), .o_tx_go(txg), .o_xtal_ready(xr), .o_vco_corr(vco),
        .o_modem(modem), .o_ook_pre_bits(ook), .o_osc_det_en(odet), .o_cp_test(cpt),
        .o_cp_gain(cpg), .o_cp_corr(cpc), .o_div_trim(dvt));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Cycles until a monitored output rises (t), then cycles high (n)
    task automatic meas(input int b);
        t = 0;
        n = 0;
        #1;
        while (!mon[b] && t < 100) begin @(posedge clk); #1; t++; end
        while (mon[b] && n < 100) begin @(posedge clk); #1; n++; end
    endtask : meas
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        `CHK(d, e)
    endtask : rd_chk
    task automatic txreq;
        @(posedge clk) txr <= 1'b1;
        @(posedge clk) txr <= 1'b0;
    endtask : txreq

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        rd_chk(8'h55, 8'h44);
        rd_chk(8'h56, 8'h00);
        rd_chk(8'h58, 8'h80);
        rd_chk(8'h5A, 8'h00);
        `CHK(cpc, 5'h00)
    endtask : t_reset
    task automatic t_modem;
        for (int i = 0; i < 8; i++) begin
            host.wr(8'h56, 8'h01 << i);
            rd_chk(8'h56, 8'h01 << i);
            `CHK(modem, 8'h01 << i)
            `CHK(ook, (i == 3) ? 4'h8 : 4'h4)
            `CHK(odet, (i != 4))
        end
        host.wr(8'h56, 8'h00);
    endtask : t_modem
    task automatic t_rsv;
        host.wr(8'h55, 8'hA0);
        rd_chk(8'h55, 8'h00);
        host.wr(8'h5A, 8'hFF);
        rd_chk(8'h56, 8'h00);
        host.wr(8'h57, 8'hA5);
        rd_chk(8'h57, 8'hA5);
        `CHK(cpt, 8'hA5)
    endtask : t_rsv
    task automatic t_rc;
        @(posedge clk) rco <= 1'b1;
        host.wr(8'h55, 8'h08);
        meas(0);
        `CHK(t, 0)
        `CHK(n, RC)
        rd_chk(8'h55, 8'h00);
        @(posedge clk) rco <= 1'b0;
        host.wr(8'h55, 8'h08);
        meas(0);
        `CHK(t, 100)
        rd_chk(8'h55, 8'h00);
    endtask : t_rc
    task automatic t_wut_fine;
        @(posedge clk) rco <= 1'b1;
        @(posedge clk) wut <= 1'b1;
        @(posedge clk);
        meas(0);
        `CHK(t <= 1, 1'b1)
        `CHK(n, RC)
        @(posedge clk) wut <= 1'b0;
        host.wr(8'h55, 8'h10);
        for (int k = 0; k < 2; k++) begin
            meas(0);
            `CHK(t > 0 && t <= FINE + 1, 1'b1)
            `CHK(n, RC)
        end
        host.wr(8'h55, 8'h00);
    endtask : t_wut_fine
    task automatic t_vco;
        for (int k = 0; k < 2; k++) begin
            host.wr(8'h55, k ? 8'h04 : 8'h00);
            txreq();
            meas(1);
            `CHK(n, k ? 2 * VC : VC)
            `CHK(vcl, (k == 1))
            `CHK(txg, 1'b1)
        end
        host.wr(8'h55, 8'h01);
        txreq();
        meas(2);
        `CHK(t, 0)
        `CHK(n, 1)
        `CHK(vcb, 1'b0)
        @(posedge clk) pllon <= 1'b1;
        @(posedge clk) idle <= 1'b1;
        host.wr(8'h55, 8'h02);
        meas(1);
        `CHK(n, VC)
        rd_chk(8'h55, 8'h00);
        @(posedge clk) pllon <= 1'b0;
        host.wr(8'h55, 8'h02);
        meas(1);
        `CHK(t, 100)
    endtask : t_vco
    task automatic t_xtal;
        for (int h = 0; h < 2; h++) begin
            host.wr(8'h55, h ? 8'h40 : 8'h00);
            @(posedge clk) xws <= 1'b1;
            @(posedge clk) xws <= 1'b0;
            meas(3);
            `CHK(t, h ? XW / 2 : XW)
            `CHK(n, 1)
        end
    endtask : t_xtal
    task automatic t_cp_boost;
        @(posedge clk) cpa <= 5'h0A;
        host.wr(8'h58, 8'h80);
        rd_chk(8'h58, 8'h8A);
        `CHK(cpc, 5'h0A)
        host.wr(8'h58, 8'hB5);
        rd_chk(8'h58, 8'hB5);
        `CHK(cpc, 5'h15)
        `CHK(cpg, 2'h2)
        @(posedge clk) vci <= 4'h3;
        host.wr(8'h59, 8'h80);
        rd_chk(8'h59, 8'h80);
        `CHK(dvt, 8'h80)
        txreq();
        repeat (3) @(posedge clk);
        #1 `CHK(vco, 4'hF)
        meas(1);
        @(posedge clk) txm <= 1'b1;
        @(posedge clk);
        #1 `CHK(vco, 4'hF)
        @(posedge clk) txm <= 1'b0;
        @(posedge clk);
        #1 `CHK(vco, 4'h3)
    endtask : t_cp_boost

    task automatic wrap_up;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_modem();
        t_rsv();
        t_rc();
        t_wut_fine();
        t_vco();
        t_xtal();
        t_cp_boost();
        wrap_up();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        #100us;
        err_count++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
